// *** inc/iasf_pkg.sv ***
// Constants, types and helpers shared by the indirect addressing and status flag unit.
package iasf_pkg;

  localparam int IASF_ADDR_W = 12;
  localparam int IASF_DATA_W = 8;
  localparam int IASF_PTR_COUNT = 3;

  // Data-space map of the access ports, pointer bytes and status register.
  localparam logic [11:0] IASF_PORT_BASE = 12'hFE0;
  localparam logic [2:0] IASF_PORT_SLOTS = 3'h5;
  localparam logic [11:0] IASF_PTR_BYTE_BASE = 12'hFD0;
  localparam logic [11:0] IASF_STATUS_ADDR = 12'hFD8;

  // Values after reset.
  localparam logic [11:0] IASF_PTR_RESET = 12'h000;
  localparam logic [4:0] IASF_FLAGS_RESET = 5'h00;

  // Field positions inside the flag register.
  localparam int IASF_FLAG_C = 0;
  localparam int IASF_FLAG_DC = 1;
  localparam int IASF_FLAG_Z = 2;
  localparam int IASF_FLAG_OV = 3;
  localparam int IASF_FLAG_N = 4;
  localparam int IASF_FLAG_W = 5;

  // Register bus map, byte addresses.
  localparam int IASF_AXI_ADDR_W = 8;
  localparam logic [7:0] IASF_AXI_PTR_BASE = 8'h00;
  localparam logic [7:0] IASF_AXI_FLAGS = 8'h10;
  localparam logic [1:0] IASF_RESP_OKAY = 2'h0;
  localparam logic [1:0] IASF_RESP_SLVERR = 2'h2;

  // Access location inside a pointer's port block, in address order.
  typedef enum logic [2:0] {
    IASF_MODE_PLAIN,
    IASF_MODE_POST_DEC,
    IASF_MODE_POST_INC,
    IASF_MODE_PRE_INC,
    IASF_MODE_INDEXED
  } iasf_mode_t;

  // Operation that produces the value written by an access.
  typedef enum logic [3:0] {
    IASF_KIND_MOVE,
    IASF_KIND_CLEAR,
    IASF_KIND_ADD,
    IASF_KIND_SUB,
    IASF_KIND_AND,
    IASF_KIND_OR,
    IASF_KIND_XOR,
    IASF_KIND_ROT_LEFT,
    IASF_KIND_ROT_RIGHT
  } iasf_kind_t;

  // True when an address falls on one of the indirect access ports.
  function automatic logic iasf_is_port(input logic [11:0] addr, input int count);
    logic [11:0] off;
    off = addr - IASF_PORT_BASE;
    return (addr >= IASF_PORT_BASE) && (int'(off[11:3]) < count)
      && (off[2:0] < IASF_PORT_SLOTS);
  endfunction : iasf_is_port

endpackage : iasf_pkg

// *** src/iasf_flag_calc.sv ***
// Result and arithmetic flag computation for one operation.
`timescale 1ns/1ns
module iasf_flag_calc
  import iasf_pkg::*;
(
  input wire iasf_kind_t i_kind, // Operation to perform.
  input wire logic [7:0] i_a, // First operand, minuend for subtraction.
  input wire logic [7:0] i_b, // Second operand.
  input wire logic i_carry, // Current carry flag.
  output logic [7:0] o_result, // Operation result.
  output logic [IASF_FLAG_W-1:0] o_flags, // Flag values from this result.
  output logic [IASF_FLAG_W-1:0] o_mask // Flags this operation affects.
);

  logic is_sub;
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction adds the two's complement, so carry reads as not-borrow.
  assign is_sub = (i_kind == IASF_KIND_SUB);
  assign b_eff = is_sub ? ~i_b : i_b;
  assign sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, is_sub};
  assign nib = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

  always_comb
  begin
    o_result = i_a;
    o_flags = '0;
    o_mask = '0;
    unique case (i_kind)
      IASF_KIND_MOVE:
      begin
        o_result = i_a;
      end
      IASF_KIND_CLEAR:
      begin
        o_result = 8'h00;
        o_mask[IASF_FLAG_Z] = 1'b1;
      end
      IASF_KIND_ADD, IASF_KIND_SUB:
      begin
        o_result = sum[7:0];
        o_mask = 5'h1F;
        o_flags[IASF_FLAG_C] = sum[8];
        o_flags[IASF_FLAG_DC] = nib[4];
        o_flags[IASF_FLAG_OV] = (i_a[7] == b_eff[7]) && (sum[7] != i_a[7]);
      end
      IASF_KIND_AND, IASF_KIND_OR, IASF_KIND_XOR:
      begin
        o_result = (i_kind == IASF_KIND_AND) ? (i_a & i_b)
          : (i_kind == IASF_KIND_OR) ? (i_a | i_b) : (i_a ^ i_b);
        o_mask[IASF_FLAG_Z] = 1'b1;
        o_mask[IASF_FLAG_N] = 1'b1;
      end
      IASF_KIND_ROT_LEFT:
      begin
        o_result = {i_a[6:0], i_carry};
        o_mask = 5'h17;
        o_flags[IASF_FLAG_C] = i_a[7];
        o_flags[IASF_FLAG_DC] = i_a[3];
      end
      IASF_KIND_ROT_RIGHT:
      begin
        o_result = {i_carry, i_a[7:1]};
        o_mask = 5'h17;
        o_flags[IASF_FLAG_C] = i_a[0];
        o_flags[IASF_FLAG_DC] = i_a[4];
      end
      default:
      begin
        o_result = i_a;
      end
    endcase
    o_flags[IASF_FLAG_N] = o_result[7];
    o_flags[IASF_FLAG_Z] = (o_result == 8'h00);
  end

endmodule : iasf_flag_calc

// *** src/iasf_indirect_unit.sv ***
// Indirect data addressing with three pointers and the arithmetic flag register.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module iasf_indirect_unit
  import iasf_pkg::*;
#(
  parameter int PTR_COUNT = IASF_PTR_COUNT
)
(
  input wire logic i_clk_sys, // System clock.
  input wire logic i_reset, // Synchronous reset, active high.
  input wire logic i_op_valid, // Core access request.
  input wire logic i_op_write, // Access writes when high, reads when low.
  input wire logic [11:0] i_op_addr, // Operand address of the access.
  input wire iasf_kind_t i_op_kind, // Operation producing the written value.
  input wire logic [7:0] i_op_a, // First operand of the operation.
  input wire logic [7:0] i_op_b, // Second operand of the operation.
  input wire logic [7:0] i_working_register, // Working register value.
  output logic o_op_rvalid, // Read data valid pulse.
  output logic [7:0] o_op_rdata, // Read data.
  output logic [7:0] o_alu_flags, // Flag register as read.
  output logic o_ram_en, // Data memory access strobe.
  output logic o_ram_we, // Data memory write strobe.
  output logic [11:0] o_ram_addr, // Data memory address.
  output logic [7:0] o_ram_wdata, // Data memory write data.
  input wire logic [7:0] i_ram_rdata, // Data memory read data, same cycle.
  input wire logic [IASF_AXI_ADDR_W-1:0] i_awaddr, // AXI write address.
  input wire logic i_awvalid, // AXI write address valid.
  output logic o_awready, // AXI write address ready.
  input wire logic [31:0] i_wdata, // AXI write data.
  input wire logic [3:0] i_wstrb, // AXI write strobes.
  input wire logic i_wvalid, // AXI write data valid.
  output logic o_wready, // AXI write data ready.
  output logic [1:0] o_bresp, // AXI write response.
  output logic o_bvalid, // AXI write response valid.
  input wire logic i_bready, // AXI write response ready.
  input wire logic [IASF_AXI_ADDR_W-1:0] i_araddr, // AXI read address.
  input wire logic i_arvalid, // AXI read address valid.
  output logic o_arready, // AXI read address ready.
  output logic [31:0] o_rdata, // AXI read data.
  output logic [1:0] o_rresp, // AXI read response.
  output logic o_rvalid, // AXI read data valid.
  input wire logic i_rready // AXI read data ready.
);

  logic [PTR_COUNT-1:0][11:0] ptr_q;
  logic [IASF_FLAG_W-1:0] flags_q;
  logic [PTR_COUNT-1:0][11:0] next_ptr;
  logic [IASF_FLAG_W-1:0] next_flags;

  // Decode of the operand address onto a pointer's port block.
  wire logic [11:0] port_off = i_op_addr - IASF_PORT_BASE;
  wire logic ind_hit = iasf_is_port(i_op_addr, PTR_COUNT);
  wire logic [1:0] ind_sel = port_off[4:3];
  wire iasf_mode_t ind_mode = iasf_mode_t'(port_off[2:0]);
  wire logic [11:0] cur_ptr = ptr_q[ind_sel];
  wire logic [11:0] working_register_sext = {{4{i_working_register[7]}}, i_working_register};
  wire logic [11:0] ptr_plus = cur_ptr + 12'h001;
  wire logic [11:0] ptr_minus = cur_ptr - 12'h001;
  wire logic [11:0] ptr_index = cur_ptr + working_register_sext;

  // Effective address and the pointer value after the access.
  wire logic [11:0] eff_addr = (ind_mode == IASF_MODE_PRE_INC) ? ptr_plus
    : (ind_mode == IASF_MODE_INDEXED) ? ptr_index : cur_ptr;
  wire logic step_en = ind_hit && ((ind_mode == IASF_MODE_POST_DEC)
    || (ind_mode == IASF_MODE_POST_INC) || (ind_mode == IASF_MODE_PRE_INC));
  wire logic [11:0] step_ptr = (ind_mode == IASF_MODE_POST_DEC) ? ptr_minus
    : ptr_plus;

  // Classification of the final target.
  wire logic [11:0] target = ind_hit ? eff_addr : i_op_addr;
  wire logic tgt_port = ind_hit && iasf_is_port(eff_addr, PTR_COUNT);
  wire logic tgt_status = !tgt_port && (target == IASF_STATUS_ADDR);
  wire logic [11:0] pb_off = target - IASF_PTR_BYTE_BASE;
  wire logic tgt_ptr_byte = !tgt_port && (target >= IASF_PTR_BYTE_BASE)
    && (int'(pb_off) < 2 * PTR_COUNT);
  wire logic [1:0] pb_sel = pb_off[2:1];
  wire logic pb_high = pb_off[0];
  wire logic tgt_ram = !tgt_port && !tgt_status && !tgt_ptr_byte;

  // Operation result and flags.
  logic [7:0] calc_result;
  logic [IASF_FLAG_W-1:0] calc_flags;
  logic [IASF_FLAG_W-1:0] calc_mask;

  iasf_flag_calc u_calc (
    .i_kind(i_op_kind),
    .i_a(i_op_a),
    .i_b(i_op_b),
    .i_carry(flags_q[IASF_FLAG_C]),
    .o_result(calc_result),
    .o_flags(calc_flags),
    .o_mask(calc_mask)
  );

  wire logic op_wr = i_op_valid && i_op_write && !tgt_port;
  wire logic port_rd = i_op_valid && !i_op_write && tgt_port;
  wire logic flag_upd = op_wr && (calc_mask != '0);
  wire logic status_plain_wr = op_wr && tgt_status && (calc_mask == '0);
  wire logic byte_wr = op_wr && tgt_ptr_byte;

  // Register bus slave state.
  logic aw_held;
  logic w_held;
  logic [IASF_AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire logic do_write = aw_held && w_held && !o_bvalid;
  wire logic [1:0] wr_idx = aw_addr_q[3:2];
  wire logic wr_ptr_hit = (int'(aw_addr_q[7:2]) < PTR_COUNT);
  wire logic wr_flags_hit = (aw_addr_q[7:2] == IASF_AXI_FLAGS[7:2]);
  wire logic axi_flags_wr = do_write && wr_flags_hit && w_strb_q[0];
  wire logic axi_ptr_wr_any = do_write && wr_ptr_hit && (w_strb_q[1:0] != 2'h0);
  wire logic [11:0] axi_ptr_val = {w_strb_q[1] ? w_data_q[11:8] : ptr_q[wr_idx][11:8],
    w_strb_q[0] ? w_data_q[7:0] : ptr_q[wr_idx][7:0]};
  wire logic ar_take = i_arvalid && o_arready;
  wire logic [1:0] rd_idx = i_araddr[3:2];
  wire logic rd_ptr_hit = (int'(i_araddr[7:2]) < PTR_COUNT);
  wire logic rd_flags_hit = (i_araddr[7:2] == IASF_AXI_FLAGS[7:2]);
  wire logic [31:0] rd_word = rd_ptr_hit ? {20'h00000, ptr_q[rd_idx]}
    : rd_flags_hit ? {27'h0000000, flags_q} : 32'h00000000;

  // Pointer next values; a core byte write beats a step, a step beats the bus.
  for (genvar n = 0; n < PTR_COUNT; n++)
  begin : g_ptr
    wire logic byte_wr_n = byte_wr && (pb_sel == 2'(n));
    wire logic step_n = i_op_valid && step_en && (ind_sel == 2'(n));
    wire logic axi_n = axi_ptr_wr_any && (wr_idx == 2'(n));
    assign next_ptr[n] = byte_wr_n ? (pb_high ? {calc_result[3:0], ptr_q[n][7:0]}
      : {ptr_q[n][11:8], calc_result})
      : step_n ? step_ptr
      : axi_n ? axi_ptr_val : ptr_q[n];
  end

  // Flags change only through operations, port reads, status writes or the bus.
  assign next_flags = port_rd ? (flags_q | 5'h04)
    : flag_upd ? ((flags_q & ~calc_mask) | (calc_flags & calc_mask))
    : status_plain_wr ? calc_result[4:0]
    : axi_flags_wr ? w_data_q[4:0] : flags_q;

  // Data returned for targets that are not in data memory.
  wire logic [7:0] local_rd = tgt_port ? 8'h00
    : tgt_status ? {3'h0, flags_q}
    : pb_high ? {4'h0, ptr_q[pb_sel][11:8]} : ptr_q[pb_sel][7:0];

  logic s_rd;
  logic s_from_ram;
  logic [7:0] s_local;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      ptr_q <= {PTR_COUNT{IASF_PTR_RESET}};
      flags_q <= IASF_FLAGS_RESET;
    end
    else
    begin
      ptr_q <= next_ptr;
      flags_q <= next_flags;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_ram_en <= 1'b0;
      o_ram_we <= 1'b0;
      o_ram_addr <= 12'h000;
      o_ram_wdata <= 8'h00;
      s_rd <= 1'b0;
      s_from_ram <= 1'b0;
      s_local <= 8'h00;
    end
    else
    begin
      o_ram_en <= i_op_valid && tgt_ram;
      o_ram_we <= op_wr && tgt_ram;
      o_ram_addr <= target;
      o_ram_wdata <= calc_result;
      s_rd <= i_op_valid && !i_op_write;
      s_from_ram <= tgt_ram;
      s_local <= local_rd;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_op_rvalid <= 1'b0;
      o_op_rdata <= 8'h00;
    end
    else
    begin
      o_op_rvalid <= s_rd;
      o_op_rdata <= s_from_ram ? i_ram_rdata : s_local;
    end
  end

  assign o_alu_flags = {3'h0, flags_q};

  // Register bus: address and data are held independently, then written together.
  assign o_awready = !aw_held;
  assign o_wready = !w_held;
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= IASF_RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= (wr_ptr_hit || wr_flags_hit) ? IASF_RESP_OKAY : IASF_RESP_SLVERR;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= IASF_RESP_OKAY;
    end
    else if (ar_take)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= (rd_ptr_hit || rd_flags_hit) ? IASF_RESP_OKAY : IASF_RESP_SLVERR;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

  // Helper state that lets the checks below find the pointer that was touched.
  logic [1:0] chk_sel;
  logic [1:0] chk_pb;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      chk_sel <= 2'h0;
      chk_pb <= 2'h0;
    end
    else
    begin
      chk_sel <= ind_sel;
      chk_pb <= pb_sel;
    end
  end

  wire logic chk_clean = !byte_wr && !axi_ptr_wr_any;
  wire logic chk_ind = i_op_valid && ind_hit && chk_clean && tgt_ram;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  a_plain_ptr_hold: assert property (
    i_op_valid && ind_hit && (ind_mode == IASF_MODE_PLAIN) && chk_clean
    |=> $stable(ptr_q) && (o_ram_addr == $past(cur_ptr)))
  else $error("Plain indirect access moved its pointer.");

  a_post_dec_step: assert property (
    chk_ind && (ind_mode == IASF_MODE_POST_DEC)
    |=> (o_ram_addr == $past(cur_ptr)) && (ptr_q[chk_sel] == $past(cur_ptr) - 12'h001))
  else $error("Post-decrement address or step is wrong.");

  a_post_inc_wrap: assert property (
    chk_ind && (ind_mode == IASF_MODE_POST_INC)
    |=> (o_ram_addr == $past(cur_ptr)) && (ptr_q[chk_sel] == $past(cur_ptr) + 12'h001))
  else $error("Post-increment address or step is wrong.");

  a_pre_inc_addr: assert property (
    chk_ind && (ind_mode == IASF_MODE_PRE_INC)
    |=> (o_ram_addr == $past(cur_ptr) + 12'h001) && (ptr_q[chk_sel] == o_ram_addr))
  else $error("Pre-increment did not use the stepped pointer.");

  a_indexed_addr: assert property (
    chk_ind && (ind_mode == IASF_MODE_INDEXED)
    |=> (o_ram_addr == $past(cur_ptr) + $past(working_register_sext)) && $stable(ptr_q))
  else $error("Indexed address is wrong or pointer changed.");

  a_step_no_flags: assert property (
    i_op_valid && step_en && !i_op_write && !tgt_port && !axi_flags_wr
    |=> $stable(flags_q))
  else $error("Pointer step changed the flags.");

  a_port_read_zero: assert property (
    port_rd |=> flags_q[IASF_FLAG_Z] ##1 (o_op_rvalid && (o_op_rdata == 8'h00)))
  else $error("Read of an access port was not zero with zero flag.");

  a_port_write_nop: assert property (
    i_op_valid && i_op_write && tgt_port && !axi_flags_wr
    |=> !o_ram_we && $stable(flags_q))
  else $error("Write to an access port had an effect.");

  a_byte_write_wins: assert property (
    byte_wr && !pb_high && step_en && (ind_sel == pb_sel)
    |=> ptr_q[chk_pb][7:0] == $past(calc_result))
  else $error("Pointer step overrode a pointer byte write.");

  a_status_clear_z: assert property (
    op_wr && tgt_status && (i_op_kind == IASF_KIND_CLEAR)
    |=> flags_q[IASF_FLAG_Z] && ((flags_q & 5'h1B) == ($past(flags_q) & 5'h1B)))
  else $error("Clearing the status register did not just set zero.");

  a_upper_bits_zero: assert property (
    o_alu_flags[7:5] == 3'h0)
  else $error("Unimplemented flag bits read nonzero.");

endmodule : iasf_indirect_unit

// *** tb/iasf_ram_model.sv ***
// Behavioural data memory that answers the indirect unit.
`timescale 1ns/1ns
module iasf_ram_model
(
  input wire logic i_clk_sys, // System clock.
  input wire logic i_en, // Access strobe.
  input wire logic i_we, // Write strobe.
  input wire logic [11:0] i_addr, // Address.
  input wire logic [7:0] i_wdata, // Write data.
  output logic [7:0] o_rdata // Read data.
);
  logic [7:0] mem [0:4095];
  logic [7:0] last;
  // Unselected, the data lines show the inverse of the last value read.
  assign o_rdata = i_en ? mem[i_addr] : ~last;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    last = 8'h00;
  end
  always @(posedge i_clk_sys)
  begin
    if (i_en)
      last <= mem[i_addr];
    if (i_en && i_we)
      mem[i_addr] <= i_wdata;
  end
endmodule : iasf_ram_model

// *** tb/iasf_indirect_unit_bench.sv ***
// Self-checking testbench of the indirect addressing and flag unit.
`timescale 1ns/1ns
module iasf_indirect_unit_bench
  import iasf_pkg::*;
;
  logic clk, rst, op_v, op_w, rv, ram_en, ram_we, awv, awr, wv, wr, bv, br, arv, arr, rvl, rr;
  logic [11:0] op_a, ram_a;
  logic [7:0] a_in, b_in, working_register, rd, flags, ram_wd, ram_rd, awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  iasf_kind_t kind;
  int bad_count = 0;
  int checks_done = 0;
  int ram_writes = 0;
  int n;
  iasf_kind_t tk [0:10] = '{IASF_KIND_ADD, IASF_KIND_ADD, IASF_KIND_SUB, IASF_KIND_SUB,
    IASF_KIND_ROT_LEFT, IASF_KIND_ROT_RIGHT, IASF_KIND_AND, IASF_KIND_OR, IASF_KIND_CLEAR,
    IASF_KIND_XOR, IASF_KIND_MOVE};
  // Each entry holds operand a, operand b, expected flags and expected stored result.
  logic [31:0] tv [0:10] = '{32'h7F011A80, 32'hFF010700, 32'h000110FF, 32'h8001097F,
    32'h88000B11, 32'h11001B88, 32'h0FF00F00, 32'h80001B80, 32'h00001F00, 32'hFFFF0F00,
    32'h55000F55};

  iasf_indirect_unit dut (.i_clk_sys(clk), .i_reset(rst), .i_op_valid(op_v),
    .i_op_write(op_w), .i_op_addr(op_a), .i_op_kind(kind), .i_op_a(a_in), .i_op_b(b_in),
    .i_working_register(working_register), .o_op_rvalid(rv), .o_op_rdata(rd), .o_alu_flags(flags),
    .o_ram_en(ram_en), .o_ram_we(ram_we), .o_ram_addr(ram_a), .o_ram_wdata(ram_wd),
    .i_ram_rdata(ram_rd), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(br), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat),
    .o_rresp(rresp), .o_rvalid(rvl), .i_rready(rr));

  iasf_ram_model ram (.i_clk_sys(clk), .i_en(ram_en), .i_we(ram_we), .i_addr(ram_a),
    .i_wdata(ram_wd), .o_rdata(ram_rd));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (ram_en && ram_we)
      ram_writes <= ram_writes + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic op(input logic w, input logic [11:0] ad, input iasf_kind_t k,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] exp);
    @(posedge clk);
    op_v <= 1'b1;
    op_w <= w;
    op_a <= ad;
    kind <= k;
    a_in <= a;
    b_in <= b;
    @(posedge clk);
    op_v <= 1'b0;
    // One edge after the take edge the read answer is standing.
    @(posedge clk);
    #1;
    if (!w)
    begin
      chk(rv, 1'b1, "read valid");
      chk(rd, exp, "read data");
    end
  endtask : op

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wr)
        wv <= 1'b0;
    end
    while (!bv);
    br <= 1'b0;
    chk(bresp, er, "write response");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arv && arr)
        arv <= 1'b0;
    end
    while (!rvl);
    rr <= 1'b0;
    chk(rdat, exp, "register read");
    chk(rresp, er, "read response");
  endtask : axi_rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    {op_v, op_w, awv, wv, br, arv, rr} = '0;
    op_a = 12'h000;
    kind = IASF_KIND_MOVE;
    {a_in, b_in, working_register, awa, ara} = '0;
    wd = 32'h0;
    ws = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(flags, 8'h00, "flags after reset");
    axi_rd(8'h00, 32'h0, IASF_RESP_OKAY);
    axi_rd(IASF_AXI_FLAGS, 32'h0, IASF_RESP_OKAY);
    axi_wr(8'h20, 32'hFF, IASF_RESP_SLVERR);
    axi_rd(8'h20, 32'h0, IASF_RESP_SLVERR);
    axi_wr(8'h08, 32'hABC, IASF_RESP_OKAY);
    axi_rd(8'h08, 32'hABC, IASF_RESP_OKAY);
    // Only the low byte strobe is set, so the high pointer bits must be kept.
    @(posedge clk);
    ws <= 4'h1;
    axi_wr(8'h08, 32'h123, IASF_RESP_OKAY);
    axi_rd(8'h08, 32'hA23, IASF_RESP_OKAY);
    @(posedge clk);
    ws <= 4'hF;
    $display("test reset and registers done");
    axi_wr(8'h00, 32'h100, IASF_RESP_OKAY);
    op(1'b1, 12'hFE2, IASF_KIND_MOVE, 8'hA5, 8'h00, 8'h00);
    chk(ram.mem[12'h100], 8'hA5, "post-inc store");
    axi_rd(8'h00, 32'h101, IASF_RESP_OKAY);
    op(1'b1, 12'hFE1, IASF_KIND_MOVE, 8'h5A, 8'h00, 8'h00);
    chk(ram.mem[12'h101], 8'h5A, "post-dec store");
    axi_rd(8'h00, 32'h100, IASF_RESP_OKAY);
    op(1'b0, 12'hFE3, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h5A);
    op(1'b0, 12'hFE0, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h5A);
    @(posedge clk);
    working_register <= 8'hFF;
    op(1'b0, 12'hFE4, IASF_KIND_MOVE, 8'h00, 8'h00, 8'hA5);
    axi_rd(8'h00, 32'h101, IASF_RESP_OKAY);
    $display("test access modes done");
    axi_wr(8'h04, 32'h0FF, IASF_RESP_OKAY);
    axi_wr(IASF_AXI_FLAGS, 32'h0, IASF_RESP_OKAY);
    op(1'b1, 12'hFEA, IASF_KIND_MOVE, 8'h11, 8'h00, 8'h00);
    axi_rd(8'h04, 32'h100, IASF_RESP_OKAY);
    axi_wr(8'h04, 32'hFFF, IASF_RESP_OKAY);
    op(1'b1, 12'hFEA, IASF_KIND_MOVE, 8'h22, 8'h00, 8'h00);
    axi_rd(8'h04, 32'h000, IASF_RESP_OKAY);
    chk(flags, 8'h00, "flags after wrap");
    op(1'b1, 12'hFE9, IASF_KIND_MOVE, 8'h33, 8'h00, 8'h00);
    chk(ram.mem[12'h000], 8'h33, "store at zero");
    chk(ram.mem[12'hFFF], 8'h22, "store at top");
    axi_rd(8'h04, 32'hFFF, IASF_RESP_OKAY);
    $display("test stepping done");
    axi_wr(8'h08, 32'hFE0, IASF_RESP_OKAY);
    n = ram_writes;
    op(1'b1, 12'hFF0, IASF_KIND_ADD, 8'h7F, 8'h01, 8'h00);
    chk(flags, 8'h00, "flags after port write");
    chk(ram_writes, n, "memory writes");
    op(1'b0, 12'hFF0, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h00);
    chk(flags, 8'h04, "flags after port read");
    axi_wr(8'h00, 32'hFD0, IASF_RESP_OKAY);
    op(1'b1, 12'hFE2, IASF_KIND_MOVE, 8'h40, 8'h00, 8'h00);
    axi_rd(8'h00, 32'hF40, IASF_RESP_OKAY);
    $display("test port targets done");
    for (int i = 0; i < 11; i++)
    begin
      op(1'b1, 12'h200 + 12'(i), tk[i], tv[i][31:24], tv[i][23:16], 8'h00);
      chk(flags, tv[i][15:8], "flags after operation");
      chk(ram.mem[12'h200 + 12'(i)], tv[i][7:0], "stored result");
    end
    op(1'b1, IASF_STATUS_ADDR, IASF_KIND_ADD, 8'h7F, 8'h01, 8'h00);
    chk(flags, 8'h1A, "flags as destination");
    op(1'b1, IASF_STATUS_ADDR, IASF_KIND_CLEAR, 8'h00, 8'h00, 8'h00);
    chk(flags, 8'h1E, "flags after clear of status");
    op(1'b1, IASF_STATUS_ADDR, IASF_KIND_MOVE, 8'hFF, 8'h00, 8'h00);
    chk(flags, 8'h1F, "flags after move");
    axi_rd(IASF_AXI_FLAGS, 32'h1F, IASF_RESP_OKAY);
    op(1'b0, IASF_STATUS_ADDR, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h1F);
    op(1'b0, 12'hFD1, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h0F);
    op(1'b0, 12'hFD0, IASF_KIND_MOVE, 8'h00, 8'h00, 8'h40);
    $display("test flags done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(flags, 8'h00, "flags after second reset");
    axi_rd(8'h00, 32'h0, IASF_RESP_OKAY);
    axi_rd(8'h08, 32'h0, IASF_RESP_OKAY);
    $display("test second reset done");
    finish_test();
  end
endmodule : iasf_indirect_unit_bench
